// ===== cpw_pwm_timer.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Cascaded timer pair run as a PWM generator with a 16-period stretch frame.
module cpw_pwm_timer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lowSpeedClock,
    input wire logic externalCountInput,
    output logic invertedPwmOutput,
    output logic periodIrq,
    output logic frameIrq
);
    logic [7:0] modeReg;
    logic [7:0] cascadeCtlReg;
    logic [7:0] systemCtlReg;
    logic [7:0] dutyLowReg;
    logic [7:0] dutyHighReg;
    logic [7:0] bufDuty;
    logic [3:0] bufAdd;
    logic [7:0] actDuty;
    logic [3:0] actAdd;
    logic [7:0] count;
    logic [3:0] periodIdx;
    logic phase;

    cpw_core_if core ();

    cpw_source_clock u_source (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .lowSpeedClock(lowSpeedClock),
        .externalCountInput(externalCountInput),
        .core(core.src)
    );

    cpw_pulse_pattern u_pattern (
        .core(core.pattern)
    );

    // Mode decode: PWM only in cascade with the upper mode field at 10.
    wire initLevel = modeReg[cpw_pkg::CPW_MODE_INIT];
    wire bufferOn = modeReg[cpw_pkg::CPW_MODE_DBE];
    wire [1:0] modeField = modeReg[cpw_pkg::CPW_MODE_FIELD_LSB +: 2];
    wire pwmMode = cascadeCtlReg[cpw_pkg::CPW_CTL_CASCADE] &&
                   (modeField == cpw_pkg::CPW_MODE_PWM);
    wire runBit = cascadeCtlReg[cpw_pkg::CPW_CTL_RUN];
    wire running = runBit && pwmMode;

    // Settings handed to the clock source and the pattern decoder.
    assign core.clockSelect = modeReg[cpw_pkg::CPW_MODE_CKSEL_LSB +: 3];
    assign core.extSelect = modeReg[cpw_pkg::CPW_MODE_EXT];
    assign core.slowMode = systemCtlReg[cpw_pkg::CPW_SYS_SLOW];
    assign core.altDivider = systemCtlReg[cpw_pkg::CPW_SYS_ALTDIV];
    assign core.periodIndex = periodIdx;
    assign core.additionalPulseBits = actAdd;

    // Bus address decode; only aligned words inside the map answer without pslverr.
    wire [7:0] wordIdx = paddr[9:2];
    wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire hitLow = aligned && (wordIdx == cpw_pkg::CPW_IDX_DUTY_LOW);
    wire hitHigh = aligned && (wordIdx == cpw_pkg::CPW_IDX_DUTY_HIGH);
    wire hitMode = aligned && (wordIdx == cpw_pkg::CPW_IDX_MODE);
    wire hitCtl = aligned && (wordIdx == cpw_pkg::CPW_IDX_CASCADE_CTL);
    wire hitSys = aligned && (wordIdx == cpw_pkg::CPW_IDX_SYSTEM_CTL);
    wire hitStat = aligned && (wordIdx == cpw_pkg::CPW_IDX_STATUS);
    wire hitCount = aligned && (wordIdx == cpw_pkg::CPW_IDX_COUNT);
    wire mapped = hitLow | hitHigh | hitMode | hitCtl | hitSys |
                  hitStat | hitCount;

    // One wait state: the answer comes in the second access cycle.
    wire accessWait = psel && penable && !pready;
    wire wrDone = psel && penable && pready && pwrite;
    wire wrLow = wrDone && hitLow;
    wire wrHigh = wrDone && hitHigh;
    wire wrMode = wrDone && hitMode && !runBit;
    wire wrCtl = wrDone && hitCtl;
    wire wrSys = wrDone && hitSys;

    // Status word: period index, output phase and run state.
    wire [7:0] statusWord = {2'h0, running, phase, periodIdx};

    // Duty reads always show the last written values.
    wire [7:0] readValue = hitLow ? dutyLowReg
                         : hitHigh ? dutyHighReg
                         : hitMode ? modeReg
                         : hitCtl ? cascadeCtlReg
                         : hitSys ? systemCtlReg
                         : hitStat ? statusWord
                         : hitCount ? count
                         : 8'h00;

    // Combined duty formed at the high write from both nibbles.
    wire [7:0] newDuty = {pwdata[3:0], dutyLowReg[7:4]};
    wire [3:0] newAdd = dutyLowReg[3:0];

    // Match point is the duty, or duty plus one in stretched periods.
    wire [8:0] matchTarget = {1'b0, actDuty} +
                             {8'h00, core.stretchPeriod};
    wire dutyMatch = running && ({1'b0, count} == matchTarget);
    wire tick = running && core.countTick;
    wire overflow = tick && (count == cpw_pkg::CPW_COUNT_LAST);
    wire frameEnd = overflow &&
                    (periodIdx == cpw_pkg::CPW_PERIOD_LAST);
    wire bufferLoad = frameEnd && bufferOn;

    // Bus answer registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= accessWait;
            pslverr <= accessWait && !mapped;
            if (accessWait && !pwrite) begin
                prdata <= {24'h00_0000, readValue};
            end
        end
    end

    // Control registers; mode writes are ignored while running.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modeReg <= cpw_pkg::CPW_RST_CTRL;
            cascadeCtlReg <= cpw_pkg::CPW_RST_CTRL;
            systemCtlReg <= cpw_pkg::CPW_RST_CTRL;
        end else if (ce) begin
            if (wrMode) begin
                modeReg <= pwdata[7:0];
            end
            if (wrCtl) begin
                cascadeCtlReg <= pwdata[7:0];
            end
            if (wrSys) begin
                systemCtlReg <= pwdata[7:0];
            end
        end
    end

    // Duty registers as written, and the buffer filled on the high write.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dutyLowReg <= cpw_pkg::CPW_RST_DUTY;
            dutyHighReg <= cpw_pkg::CPW_RST_DUTY;
            bufDuty <= cpw_pkg::CPW_RST_DUTY;
            bufAdd <= cpw_pkg::CPW_RST_DUTY[3:0];
        end else if (ce) begin
            if (wrLow) begin
                dutyLowReg <= pwdata[7:0];
            end
            if (wrHigh) begin
                dutyHighReg <= pwdata[7:0];
                bufDuty <= newDuty;
                bufAdd <= newAdd;
            end
        end
    end

    // Active compare: direct when unbuffered or stopped, else at frame end.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            actDuty <= cpw_pkg::CPW_RST_DUTY;
            actAdd <= cpw_pkg::CPW_RST_DUTY[3:0];
        end else if (ce) begin
            if (wrHigh && (!bufferOn || !running)) begin
                actDuty <= newDuty;
                actAdd <= newAdd;
            end else if (bufferLoad) begin
                actDuty <= bufDuty;
                actAdd <= bufAdd;
            end
        end
    end

    // Up counter, period index and output phase.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
            periodIdx <= 4'h0;
            phase <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                count <= 8'h00;
                periodIdx <= 4'h0;
                phase <= 1'b0;
            end else if (overflow) begin
                count <= 8'h00;
                periodIdx <= periodIdx + 4'h1;
                phase <= 1'b0;
            end else begin
                if (tick) begin
                    count <= count + 8'h01;
                end
                if (dutyMatch) begin
                    phase <= 1'b1;
                end
            end
        end
    end

    // Registered outputs: pin level and interrupt request pulses.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            invertedPwmOutput <= 1'b0;
            periodIrq <= 1'b0;
            frameIrq <= 1'b0;
        end else if (ce) begin
            invertedPwmOutput <= initLevel ^ (running && phase);
            periodIrq <= overflow;
            frameIrq <= frameEnd;
        end
    end
endmodule : cpw_pwm_timer

// ===== cpw_pkg.sv
// Overview of operation
// - Inverted PWM pin starts low when initial-level bit is 0, high when 1.
// - While stopped, the PWM pin shows the initial-level bit.
// - Running counter advances per source tick; duty match toggles away from initial.
// - In selected periods the toggle happens one count later, at duty plus one.
// - With all additional-pulse bits zero, no period is ever stretched.
// - At count 256 the counter wraps to zero and the pin returns initial.
// - Every counter overflow raises the period interrupt request.
// - Every sixteenth overflow raises the frame interrupt request.
// - Clearing run stops and zeroes the counter and restores the initial level.
// - External source counts edges; it must stay under half the system clock.
// - Three-bit select picks a system or low-speed clock division.
// - Double-buffer enable bit: 0 disables, 1 enables duty buffering.
// - Buffered and running: new duty waits in buffer until frame overflow.
// - Buffered: duty register reads return the last written value.
// - Buffered and stopped: a duty write loads buffer and active compare at once.
// - Unbuffered: a duty write updates the active compare immediately.
// - Pulse bit 0 picks period 9, bit 1 5/13, bit 2 3/7/11/15, bit 3 even.
// - Low duty register first; the high write applies both halves together.
// - Duty is high register low nibble over low register high nibble.
// - PWM mode needs cascade bit 1 and upper mode field 10.
package cpw_pkg;
    // Register word indices; the byte address is four times the index.
    localparam logic [7:0] CPW_IDX_DUTY_LOW = 8'h28;
    localparam logic [7:0] CPW_IDX_DUTY_HIGH = 8'h29;
    localparam logic [7:0] CPW_IDX_MODE = 8'h30;
    localparam logic [7:0] CPW_IDX_CASCADE_CTL = 8'h31;
    localparam logic [7:0] CPW_IDX_SYSTEM_CTL = 8'h32;
    localparam logic [7:0] CPW_IDX_STATUS = 8'h33;
    localparam logic [7:0] CPW_IDX_COUNT = 8'h34;

    // Reset values.
    localparam logic [7:0] CPW_RST_DUTY = 8'hFF;
    localparam logic [7:0] CPW_RST_CTRL = 8'h00;

    // Mode register fields.
    localparam int CPW_MODE_CKSEL_LSB = 0;
    localparam int CPW_MODE_EXT = 3;
    localparam int CPW_MODE_FIELD_LSB = 4;
    localparam int CPW_MODE_DBE = 6;
    localparam int CPW_MODE_INIT = 7;
    localparam logic [1:0] CPW_MODE_PWM = 2'h2;

    // Cascade control and system control fields.
    localparam int CPW_CTL_CASCADE = 1;
    localparam int CPW_CTL_RUN = 2;
    localparam int CPW_SYS_ALTDIV = 0;
    localparam int CPW_SYS_SLOW = 1;

    // Status register fields.
    localparam int CPW_STAT_IDX_LSB = 0;
    localparam int CPW_STAT_PHASE = 4;
    localparam int CPW_STAT_RUN = 5;

    // Counter limits.
    localparam logic [7:0] CPW_COUNT_LAST = 8'hFF;
    localparam logic [3:0] CPW_PERIOD_LAST = 4'hF;

    // Division exponents per select code, system clock and low-speed clock.
    localparam logic [3:0] CPW_FAST_DIV_EXP [8] =
        '{4'hB, 4'hA, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1, 4'h0};
    localparam logic [3:0] CPW_SLOW_DIV_EXP [8] =
        '{4'h4, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
endpackage : cpw_pkg

// ===== cpw_core_if.sv
`timescale 1ns/1ps
// Carries clock choice, tick and stretch pattern between the timer parts.
interface cpw_core_if;
    logic [2:0] clockSelect;
    logic extSelect;
    logic slowMode;
    logic altDivider;
    logic countTick;
    logic [3:0] periodIndex;
    logic [3:0] additionalPulseBits;
    logic stretchPeriod;

    modport ctrl (
        output clockSelect, extSelect, slowMode, altDivider,
        output periodIndex, additionalPulseBits,
        input countTick, stretchPeriod
    );
    modport src (
        input clockSelect, extSelect, slowMode, altDivider,
        output countTick
    );
    modport pattern (
        input periodIndex, additionalPulseBits,
        output stretchPeriod
    );
endinterface : cpw_core_if

// ===== cpw_pulse_pattern.sv
`timescale 1ns/1ps
// Decides whether the current period of the frame gets the extra count.
module cpw_pulse_pattern (
    cpw_core_if.pattern core
);
    // Period number is index plus one; each bit owns a fixed set of periods.
    wire [3:0] idx = core.periodIndex;
    wire [3:0] add = core.additionalPulseBits;
    wire pick0 = add[0] && (idx == 4'h8);
    wire pick1 = add[1] && (idx[2:0] == 3'h4);
    wire pick2 = add[2] && (idx[1:0] == 2'h2);
    wire pick3 = add[3] && idx[0];

    // All bits zero leaves every period unstretched.
    assign core.stretchPeriod = pick0 | pick1 | pick2 | pick3;
endmodule : cpw_pulse_pattern

// ===== cpw_source_clock.sv
`timescale 1ns/1ps
// Produces one-cycle count ticks from the chosen source clock.
module cpw_source_clock (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic lowSpeedClock,
    input wire logic externalCountInput,
    cpw_core_if.src core
);
    logic [1:0] fsSync;
    logic fsLast;
    logic [3:0] fsCnt;
    logic [1:0] extSync;
    logic extLast;
    logic [10:0] preCnt;

    // True once every two to the k counts of the given counter.
    function automatic logic divTick(input logic [10:0] cnt,
                                     input logic [3:0] k);
        logic [11:0] mask;
        mask = (12'h001 << k) - 12'h001;
        return (cnt & mask[10:0]) == mask[10:0];
    endfunction : divTick

    // Edges are taken only after two synchroniser stages.
    wire fsRise = fsSync[1] && !fsLast;
    wire extFall = !extSync[1] && extLast;
    wire [2:0] sel = core.clockSelect;
    wire lowCode = (sel == 3'h0) || (sel == 3'h1);
    wire useSlow = lowCode ? (core.slowMode || core.altDivider)
                 : (sel == 3'h7) && core.slowMode;
    wire fastTick = divTick(preCnt, cpw_pkg::CPW_FAST_DIV_EXP[sel]);
    wire slowTick = fsRise &&
        divTick({7'h00, fsCnt}, cpw_pkg::CPW_SLOW_DIV_EXP[sel]);
    wire nextTick = core.extSelect ? extFall
                  : (useSlow ? slowTick : fastTick);

    // Synchronisers, prescalers and the registered tick.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fsSync <= 2'h0;
            fsLast <= 1'b0;
            fsCnt <= 4'h0;
            extSync <= 2'h0;
            extLast <= 1'b0;
            preCnt <= 11'h000;
            core.countTick <= 1'b0;
        end else if (ce) begin
            fsSync <= {fsSync[0], lowSpeedClock};
            fsLast <= fsSync[1];
            extSync <= {extSync[0], externalCountInput};
            extLast <= extSync[1];
            preCnt <= preCnt + 11'h001;
            if (fsRise) begin
                fsCnt <= fsCnt + 4'h1;
            end
            core.countTick <= nextTick;
        end
    end
endmodule : cpw_source_clock

// ===== cpw_pwm_timer_checker.sv
`timescale 1ns/1ps
// Watches the PWM pin and interrupt pulses against shadowed controls.
module cpw_pwm_timer_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic invertedPwmOutput,
    input wire logic periodIrq,
    input wire logic frameIrq
);
    logic runReg, initLvl;
    logic [3:0] perCnt;
    logic [2:0] idleCnt;
    // Decodes completed writes; mode writes count only while stopped.
    wire busWr = psel && penable && pready && pwrite && !pslverr;
    wire ctlWr = busWr && paddr == 12'hC4;
    wire modeWr = busWr && paddr == 12'hC0 && !runReg;
    wire idleHold = idleCnt == 3'h7;
    // Shadows run bit, initial level, overflows and stopped time.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runReg <= 1'b0;
            initLvl <= 1'b0;
            perCnt <= 4'h0;
            idleCnt <= 3'h0;
        end else begin
            runReg <= ctlWr ? pwdata[2] : runReg;
            initLvl <= modeWr ? pwdata[7] : initLvl;
            perCnt <= (ctlWr || frameIrq) ? 4'h0 : perCnt + {3'h0, periodIrq};
            idleCnt <= (runReg || modeWr) ? 3'h0 :
                (idleHold ? idleCnt : idleCnt + 3'h1);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence slaveAnswer;
        !pready ##1 pready;
    endsequence
    chk_bus_answer: assert property (setupPhase |=> slaveAnswer)
        else $error("bus answer not in second access cycle");
    chk_frame_pair: assert property (frameIrq |-> periodIrq)
        else $error("frame request without overflow");
    chk_frame_count: assert property (
        periodIrq |-> frameIrq == (perCnt == 4'hF))
        else $error("frame request not on sixteenth overflow");
    chk_period_pulse: assert property (periodIrq |=> !periodIrq [*8])
        else $error("period request longer than one cycle");
    chk_stop_level: assert property (
        ctlWr && !pwdata[2] |-> ##[1:3] invertedPwmOutput == initLvl)
        else $error("pin not back at initial level after stop");
    chk_idle_level: assert property (
        idleCnt >= 3'h4 |-> invertedPwmOutput == initLvl)
        else $error("stopped pin differs from initial level");
    chk_idle_quiet: assert property (
        idleCnt >= 3'h4 |-> !periodIrq && !frameIrq)
        else $error("interrupt request while stopped");
    chk_wrap_level: assert property (
        periodIrq && runReg |-> ##[0:1] invertedPwmOutput == initLvl)
        else $error("pin not at initial level at overflow");
endmodule : cpw_pwm_timer_checker

bind cpw_pwm_timer cpw_pwm_timer_checker chk_u (.core_clk(core_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .invertedPwmOutput(invertedPwmOutput), .periodIrq(periodIrq),
    .frameIrq(frameIrq));

// ===== tb_cpw_pwm_timer.sv
`timescale 1ns/1ps
module tb_cpw_pwm_timer;
    logic core_clk, rst, ce, psel, penable, pwrite, err, initLvl;
    logic pready, pslverr, lowSpeedClock, externalCountInput;
    logic invertedPwmOutput, periodIrq, frameIrq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [31:0] seed = 32'h93EE31AB;
    logic [7:0] actD, penD;
    logic [3:0] actP, penP;
    logic [3:0] pats [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    int sh [4] = '{4, 2, 1, 0};
    int fails, checked, cycles, lowLen, pNum, e;
    bit armed, running, buffered;

    cpw_pwm_timer dut_u (.core_clk(core_clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lowSpeedClock(lowSpeedClock),
        .externalCountInput(externalCountInput),
        .invertedPwmOutput(invertedPwmOutput), .periodIrq(periodIrq),
        .frameIrq(frameIrq));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Extra count for period p (1..16) under pulse pattern m.
    function automatic int stretch(input int p, input logic [3:0] m);
        return int'((m[0] && p == 9) || (m[1] && p % 8 == 5)
            || (m[2] && p % 4 == 3) || (m[3] && p % 2 == 0));
    endfunction : stretch

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // One bus transfer held until pready, then an idle cycle.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic setMode(input logic [7:0] m);
        apb(1'b1, 12'hC0, {24'h0, m});
        initLvl = m[7];
        buffered = m[6];
        repeat (2) @(posedge core_clk);
        check(invertedPwmOutput, initLvl);
    endtask : setMode

    // Low half first, then high; the model follows the buffering mode.
    task automatic setDuty(input logic [7:0] d, input logic [3:0] p);
        apb(1'b1, 12'hA0, {24'h0, d[3:0], p});
        apb(1'b1, 12'hA4, {28'h0, d[7:4]});
        penD = d;
        penP = p;
        if (!(buffered && running)) begin
            actD = d;
            actP = p;
        end
    endtask : setDuty

    task automatic run(input bit on);
        apb(1'b1, 12'hC4, on ? 32'h6 : 32'h2);
        running = on;
        armed = 0;
        pNum = 1;
        if (!on) begin
            repeat (2) @(posedge core_clk);
            check(invertedPwmOutput, initLvl);
            apb(1'b0, 12'hD0, 0);
            check(rd, 0);
            apb(1'b0, 12'hCC, 0);
            check(rd[3:0], 0);
        end
    endtask : run

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    // Timeout, period numbering, frame loads and low-phase lengths.
    always @(posedge core_clk) begin
        cycles++;
        lowSpeedClock <= cycles[4];
        if (cycles == 60000) begin
            fails++;
            end_of_test();
        end
        if (periodIrq === 1'b1) begin
            pNum = pNum % 16 + 1;
            armed = running;
            check(frameIrq, pNum == 1);
            if (pNum == 1) begin
                actD = penD;
                actP = penP;
            end
        end
        if (invertedPwmOutput === initLvl) begin
            lowLen++;
        end else begin
            // The pin leaves its initial level one core cycle after the
            // match, so at the undivided clock a low phase is one longer.
            if (armed && lowLen > 0) begin
                check(lowLen, actD + stretch(pNum, actP) + 1);
            end
            lowLen = 0;
        end
    end

    initial begin
        rst = 1;
        ce = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        lowSpeedClock = 0;
        externalCountInput = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, 12'hA0, 0);
        check(rd, 32'hFF);
        apb(1'b0, 12'h0FC, 0);
        check(err, 1'b1);
        // Zero, each single and all pulse bits over a full frame, both initial levels.
        for (int i = 0; i < 6; i++) begin
            r = xs();
            setMode({i == 5, 7'h27});
            setDuty(8'h10 + {1'b0, r[6:0]}, pats[i]);
            run(1);
            repeat (17 * 256 + 40) @(posedge core_clk);
            run(0);
        end
        // Buffered update while running waits for the frame overflow.
        setMode(8'h67);
        setDuty(8'h30, 4'h0);
        run(1);
        @(posedge periodIrq);
        @(posedge core_clk);
        setDuty(8'h90, 4'h8);
        apb(1'b0, 12'hA0, 0);
        check(rd, 32'h08);
        apb(1'b1, 12'hC0, 32'h27);
        apb(1'b0, 12'hC0, 0);
        check(rd, 32'h67);
        repeat (33 * 256) @(posedge core_clk);
        run(0);
        // Internal divisions: count after 200 cycles within a margin.
        for (int c = 4; c < 8; c++) begin
            setMode(8'h20 | 8'(c));
            run(1);
            repeat (200) @(posedge core_clk);
            apb(1'b0, 12'hD0, 0);
            e = 200 >> sh[c - 4];
            check(rd[7:0] + 2 >= e && rd[7:0] <= e + 6, 1'b1);
            run(0);
        end
        // Slow mode: code 111 counts every fourth low-speed clock rise.
        apb(1'b1, 12'hC8, 32'h2);
        setMode(8'h27);
        run(1);
        repeat (600) @(posedge core_clk);
        apb(1'b0, 12'hD0, 0);
        check(rd[7:0] >= 4 && rd[7:0] <= 5, 1'b1);
        run(0);
        apb(1'b1, 12'hC8, 32'h0);
        // External count input: falling edges with random widths.
        setMode(8'h28);
        run(1);
        for (int k = 0; k < 20; k++) begin
            r = xs();
            externalCountInput <= 1'b1;
            repeat (3 + r[1:0]) @(posedge core_clk);
            externalCountInput <= 1'b0;
            repeat (3 + r[3:2]) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
        apb(1'b0, 12'hD0, 0);
        check(rd, 32'd20);
        run(0);
        end_of_test();
    end
endmodule : tb_cpw_pwm_timer
